/* homing_sequencer.sv */
// homing sequencer with apb register file, search patterns and offset move
// Function
// homing request ignored while interrupt positioning or multi-position run busy
// home is always the z index pulse in the slow phase, whatever the method
// zero target equals home plus offset; zero offset means zero is home
// homing starts only in position mode with servo on
// other position references and repeated requests refused while homing runs
// after home is found the axis moves through the offset to zero
// on completion absolute position monitor loads the offset distance setting
// homing done output asserted on completion
// done output not qualified by control mode or running state
// enable select accepts 0 to 3, defaults to 0
// method select accepts -2 to 35, defaults to 0 meaning no pattern
// high speed 0..8000 default 100; low speed 0..3000 default 10
// accel and decel times 0..3600000 ms, default 1000
// timeout is unsigned 32-bit milliseconds, default 60000
// offset mode accepts 0 and 1, defaults to 0
// offset distance signed 32-bit, default zero
// method -2 searches forward for end stop then z pulse
// method 1 reverse, slow at negative limit rise, reverse, nearest z
// method 2 forward, slow at positive limit rise, reverse, nearest z
// method 3 follows home switch; on-to-off in reverse slows, takes z
// timeout stops homing and flags error without done
`timescale 1ns/1ps
`default_nettype none

module homing_sequencer #(
  parameter int MS_CYCLES = homing_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive state and host request
  input wire logic homing_request,
  input wire logic position_mode,
  input wire logic servo_on,
  input wire logic interrupt_pos_busy,
  input wire logic multipos_busy,
  // sensors and position feedback
  input wire homing_pkg::sensor_in_t sensors,
  input wire logic [31:0] encoder_position,
  input wire logic zero_reached,
  // motion outputs
  output homing_pkg::motion_cmd_t motion_cmd,
  output logic [31:0] ramp_accel_ms,
  output logic [31:0] ramp_decel_ms,
  output logic goto_zero,
  output logic [31:0] zero_target,
  output logic pos_ref_accept,
  output logic homing_done_output,
  output logic homing_timeout_error,
  output logic [31:0] absolute_position_monitor
);

  // -------------------------------------------------------------------
  // state and registers
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_SLOW, ST_OFFSET} state_t;

  state_t state_ff;
  logic [1:0] homing_enable_select_ff;
  logic signed [7:0] homing_method_select_ff;
  logic signed [7:0] run_method_ff;
  logic [15:0] homing_high_speed_ff;
  logic [15:0] homing_low_speed_ff;
  logic [31:0] homing_accel_time_ff;
  logic [31:0] homing_decel_time_ff;
  logic [31:0] homing_timeout_ms_ff;
  logic homing_offset_mode_ff;
  logic signed [31:0] homing_offset_distance_ff;
  logic done_ff;
  logic tmo_err_ff;
  logic method_err_ff;
  logic [31:0] abs_pos_ff;
  logic [31:0] home_pos_ff;
  logic [31:0] zero_target_ff;
  logic goto_zero_ff;
  homing_pkg::motion_cmd_t motion_ff;
  logic request_prev_ff;
  logic nl_prev_ff;
  logic pl_prev_ff;
  logic hsw_prev_ff;
  logic [31:0] ms_div_ff;
  logic [31:0] ms_count_ff;

  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic start_ok;
  logic method_known;
  logic ms_tick;
  logic timed_out;
  logic home_found;
  logic [31:0] nxt_zero_target;

  // -------------------------------------------------------------------
  // apb access decode
  // -------------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_hit = (paddr == homing_pkg::ADDR_CTRL) || (paddr == homing_pkg::ADDR_HIGH_SPEED)
    || (paddr == homing_pkg::ADDR_LOW_SPEED) || (paddr == homing_pkg::ADDR_ACCEL)
    || (paddr == homing_pkg::ADDR_DECEL) || (paddr == homing_pkg::ADDR_TIMEOUT)
    || (paddr == homing_pkg::ADDR_OFFSET) || (paddr == homing_pkg::ADDR_STATUS)
    || (paddr == homing_pkg::ADDR_ABS_POS);
  assign pslverr = psel && penable && !addr_hit;

  // read mux; unmapped addresses read zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      unique case (paddr)
        homing_pkg::ADDR_CTRL:
        begin
          prdata[homing_pkg::CTRL_EN_LSB +: 2] = homing_enable_select_ff;
          prdata[homing_pkg::CTRL_METHOD_LSB +: 8] = homing_method_select_ff;
          prdata[homing_pkg::CTRL_OFFMODE_BIT] = homing_offset_mode_ff;
        end
        homing_pkg::ADDR_HIGH_SPEED: prdata[15:0] = homing_high_speed_ff;
        homing_pkg::ADDR_LOW_SPEED: prdata[15:0] = homing_low_speed_ff;
        homing_pkg::ADDR_ACCEL: prdata = homing_accel_time_ff;
        homing_pkg::ADDR_DECEL: prdata = homing_decel_time_ff;
        homing_pkg::ADDR_TIMEOUT: prdata = homing_timeout_ms_ff;
        homing_pkg::ADDR_OFFSET: prdata = homing_offset_distance_ff;
        homing_pkg::ADDR_STATUS:
        begin
          prdata[homing_pkg::STAT_BUSY_BIT] = (state_ff != ST_IDLE);
          prdata[homing_pkg::STAT_DONE_BIT] = done_ff;
          prdata[homing_pkg::STAT_TMO_BIT] = tmo_err_ff;
          prdata[homing_pkg::STAT_METHOD_BIT] = method_err_ff;
        end
        homing_pkg::ADDR_ABS_POS: prdata = abs_pos_ff;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // settings; an out-of-range write is dropped so the old value stays
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      homing_enable_select_ff <= homing_pkg::EN_RESET;
      homing_method_select_ff <= homing_pkg::METHOD_RESET;
      homing_offset_mode_ff <= homing_pkg::OFFMODE_RESET;
      homing_high_speed_ff <= homing_pkg::HIGH_SPEED_RESET;
      homing_low_speed_ff <= homing_pkg::LOW_SPEED_RESET;
      homing_accel_time_ff <= homing_pkg::RAMP_RESET;
      homing_decel_time_ff <= homing_pkg::RAMP_RESET;
      homing_timeout_ms_ff <= homing_pkg::TIMEOUT_RESET;
      homing_offset_distance_ff <= homing_pkg::OFFSET_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == homing_pkg::ADDR_CTRL)
      begin
        // enable field is two bits wide so 0..3 always fits
        homing_enable_select_ff <= pwdata[homing_pkg::CTRL_EN_LSB +: 2];
        if ($signed(pwdata[homing_pkg::CTRL_METHOD_LSB +: 8]) >= homing_pkg::METHOD_MIN
          && $signed(pwdata[homing_pkg::CTRL_METHOD_LSB +: 8]) <= homing_pkg::METHOD_MAX)
          homing_method_select_ff <= pwdata[homing_pkg::CTRL_METHOD_LSB +: 8];
        homing_offset_mode_ff <= pwdata[homing_pkg::CTRL_OFFMODE_BIT];
      end
      if (paddr == homing_pkg::ADDR_HIGH_SPEED && pwdata <= 32'(homing_pkg::HIGH_SPEED_MAX))
        homing_high_speed_ff <= pwdata[15:0];
      if (paddr == homing_pkg::ADDR_LOW_SPEED && pwdata <= 32'(homing_pkg::LOW_SPEED_MAX))
        homing_low_speed_ff <= pwdata[15:0];
      if (paddr == homing_pkg::ADDR_ACCEL && pwdata <= homing_pkg::RAMP_MAX)
        homing_accel_time_ff <= pwdata;
      if (paddr == homing_pkg::ADDR_DECEL && pwdata <= homing_pkg::RAMP_MAX)
        homing_decel_time_ff <= pwdata;
      if (paddr == homing_pkg::ADDR_TIMEOUT)
        homing_timeout_ms_ff <= pwdata;
      if (paddr == homing_pkg::ADDR_OFFSET)
        homing_offset_distance_ff <= pwdata;
    end
  end

  // -------------------------------------------------------------------
  // start qualification and sensor edges
  // -------------------------------------------------------------------
  // only the four implemented patterns may run; others flag a method error
  assign method_known = (homing_method_select_ff == homing_pkg::METHOD_STOP_FWD)
    || (homing_method_select_ff == homing_pkg::METHOD_NEG_LIMIT)
    || (homing_method_select_ff == homing_pkg::METHOD_POS_LIMIT)
    || (homing_method_select_ff == homing_pkg::METHOD_HOME_SW);
  // rising edge of the request; shielded by the other motion functions
  assign start_ok = homing_request && !request_prev_ff && (state_ff == ST_IDLE)
    && position_mode && servo_on && (homing_enable_select_ff != 2'h0)
    && !interrupt_pos_busy && !multipos_busy;

  // previous samples for edge detection; inputs are already synchronous
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      request_prev_ff <= 1'b0;
      nl_prev_ff <= 1'b0;
      pl_prev_ff <= 1'b0;
      hsw_prev_ff <= 1'b0;
    end
    else
    begin
      request_prev_ff <= homing_request;
      nl_prev_ff <= sensors.negative_limit_input;
      pl_prev_ff <= sensors.positive_limit_input;
      hsw_prev_ff <= sensors.home_switch_input;
    end
  end

  // -------------------------------------------------------------------
  // millisecond timeout; a setting of zero disables the watchdog
  // -------------------------------------------------------------------
  assign ms_tick = (ms_div_ff == 32'(MS_CYCLES - 1));
  assign timed_out = (state_ff != ST_IDLE) && (homing_timeout_ms_ff != 32'h0000_0000)
    && (ms_count_ff >= homing_timeout_ms_ff);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_div_ff <= 32'h0000_0000;
      ms_count_ff <= 32'h0000_0000;
    end
    else if (state_ff == ST_IDLE)
    begin
      ms_div_ff <= 32'h0000_0000;
      ms_count_ff <= 32'h0000_0000;
    end
    else
    begin
      ms_div_ff <= ms_tick ? 32'h0000_0000 : ms_div_ff + 32'h0000_0001;
      if (ms_tick)
        ms_count_ff <= ms_count_ff + 32'h0000_0001;
    end
  end

  // -------------------------------------------------------------------
  // sequencer: search, slow approach, offset move
  // -------------------------------------------------------------------
  // the home is always taken at a z pulse in the slow phase
  assign home_found = (state_ff == ST_SLOW) && sensors.z_index;
  assign nxt_zero_target = encoder_position + homing_offset_distance_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      run_method_ff <= homing_pkg::METHOD_RESET;
      motion_ff <= '0;
      goto_zero_ff <= 1'b0;
      home_pos_ff <= 32'h0000_0000;
      zero_target_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      tmo_err_ff <= 1'b0;
      method_err_ff <= 1'b0;
      abs_pos_ff <= 32'h0000_0000;
    end
    else if (timed_out)
    begin
      // stop the axis, leave done low
      state_ff <= ST_IDLE;
      motion_ff <= '0;
      goto_zero_ff <= 1'b0;
      tmo_err_ff <= 1'b1;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (start_ok && !method_known)
          begin
            method_err_ff <= 1'b1;
            done_ff <= 1'b0;
          end
          else if (start_ok)
          begin
            state_ff <= ST_FAST;
            run_method_ff <= homing_method_select_ff;
            done_ff <= 1'b0;
            tmo_err_ff <= 1'b0;
            method_err_ff <= 1'b0;
            motion_ff.active <= 1'b1;
            motion_ff.speed_rpm <= homing_high_speed_ff;
            // method 3 picks its first direction from the switch
            motion_ff.dir_fwd <= (homing_method_select_ff == homing_pkg::METHOD_STOP_FWD)
              || (homing_method_select_ff == homing_pkg::METHOD_POS_LIMIT)
              || ((homing_method_select_ff == homing_pkg::METHOD_HOME_SW)
                && !sensors.home_switch_input);
          end
        end
        ST_FAST:
        begin
          unique case (run_method_ff)
            homing_pkg::METHOD_STOP_FWD:
              if (sensors.end_stop)
              begin
                // hit and stop, then back off slowly to the nearest z
                state_ff <= ST_SLOW;
                motion_ff.dir_fwd <= 1'b0;
                motion_ff.speed_rpm <= homing_low_speed_ff;
              end
            homing_pkg::METHOD_NEG_LIMIT:
              if (sensors.negative_limit_input && !nl_prev_ff)
              begin
                state_ff <= ST_SLOW;
                motion_ff.dir_fwd <= 1'b1;
                motion_ff.speed_rpm <= homing_low_speed_ff;
              end
            homing_pkg::METHOD_POS_LIMIT:
              if (sensors.positive_limit_input && !pl_prev_ff)
              begin
                state_ff <= ST_SLOW;
                motion_ff.dir_fwd <= 1'b0;
                motion_ff.speed_rpm <= homing_low_speed_ff;
              end
            default:
            begin
              // home switch pattern: slow down on on-to-off in reverse
              if (!sensors.home_switch_input && hsw_prev_ff && !motion_ff.dir_fwd)
              begin
                state_ff <= ST_SLOW;
                motion_ff.speed_rpm <= homing_low_speed_ff;
              end
              else
                motion_ff.dir_fwd <= !sensors.home_switch_input;
            end
          endcase
        end
        ST_SLOW:
        begin
          if (home_found)
          begin
            home_pos_ff <= encoder_position;
            zero_target_ff <= nxt_zero_target;
            motion_ff <= '0;
            if (homing_offset_distance_ff == 32'sh0000_0000)
            begin
              // zero coincides with home: finish at once
              state_ff <= ST_IDLE;
              done_ff <= 1'b1;
              abs_pos_ff <= homing_offset_distance_ff;
            end
            else
            begin
              state_ff <= ST_OFFSET;
              goto_zero_ff <= 1'b1;
            end
          end
        end
        ST_OFFSET:
        begin
          // position loop carries the axis; wait for it to report arrival
          if (zero_reached)
          begin
            state_ff <= ST_IDLE;
            goto_zero_ff <= 1'b0;
            done_ff <= 1'b1;
            abs_pos_ff <= homing_offset_distance_ff;
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign motion_cmd = motion_ff;
  assign ramp_accel_ms = homing_accel_time_ff;
  assign ramp_decel_ms = homing_decel_time_ff;
  assign goto_zero = goto_zero_ff;
  assign zero_target = zero_target_ff;
  assign pos_ref_accept = (state_ff == ST_IDLE);
  // done is the flag alone; mode and servo state do not gate it
  assign homing_done_output = done_ff;
  assign homing_timeout_error = tmo_err_ff;
  assign absolute_position_monitor = abs_pos_ff;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  a_shield_request: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE) && (interrupt_pos_busy || multipos_busy) |=> (state_ff == ST_IDLE))
    else $error("homing started during interrupt or multi-position run");
  a_start_search: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok && method_known && !timed_out |=> (state_ff == ST_FAST) && motion_cmd.active)
    else $error("qualified request did not start the search");
  a_refs_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff != ST_IDLE) |-> !pos_ref_accept && !start_ok)
    else $error("position reference accepted while homing");
  a_zero_target: assert property (@(posedge pclk) disable iff (!presetn)
    home_found && !timed_out |=> zero_target == $past(nxt_zero_target))
    else $error("zero target is not home plus offset");
  a_offset_move: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done_ff) |-> $past(state_ff) == ST_OFFSET || $past(homing_offset_distance_ff) == 0)
    else $error("done raised without the offset move");
  a_abs_load: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(homing_done_output) |-> absolute_position_monitor == homing_offset_distance_ff)
    else $error("absolute position not loaded with offset");
  a_done_hold: assert property (@(posedge pclk) disable iff (!presetn)
    homing_done_output && !start_ok |=> homing_done_output)
    else $error("done output dropped without a new homing run");
  a_method1_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_FAST) && (run_method_ff == homing_pkg::METHOD_NEG_LIMIT) |-> !motion_cmd.dir_fwd)
    else $error("method 1 fast search not in reverse");
  a_method2_slow: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_SLOW) && (run_method_ff == homing_pkg::METHOD_POS_LIMIT)
    |-> !motion_cmd.dir_fwd && motion_cmd.speed_rpm == homing_low_speed_ff)
    else $error("method 2 slow phase wrong direction or speed");
  a_timeout_stop: assert property (@(posedge pclk) disable iff (!presetn)
    timed_out |=> homing_timeout_error && !homing_done_output && !motion_cmd.active)
    else $error("timeout did not stop homing");
  a_cfg_range: assert property (@(posedge pclk) disable iff (!presetn)
    homing_high_speed_ff <= homing_pkg::HIGH_SPEED_MAX && homing_low_speed_ff <= homing_pkg::LOW_SPEED_MAX
    && homing_method_select_ff >= homing_pkg::METHOD_MIN)
    else $error("setting outside its legal range");

endmodule // homing_sequencer

`default_nettype wire

/* homing_pkg.sv */
// shared constants and carrier types for the homing sequencer
package homing_pkg;

  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HIGH_SPEED = 8'h04;
  localparam logic [7:0] ADDR_LOW_SPEED = 8'h08;
  localparam logic [7:0] ADDR_ACCEL = 8'h0C;
  localparam logic [7:0] ADDR_DECEL = 8'h10;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h14;
  localparam logic [7:0] ADDR_OFFSET = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_ABS_POS = 8'h20;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_METHOD_LSB = 8;
  localparam int CTRL_OFFMODE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam int STAT_METHOD_BIT = 3;

  // -------------------------------------------------------------------
  // reset values and legal ranges
  // -------------------------------------------------------------------
  localparam logic [1:0] EN_RESET = 2'h0;
  localparam logic [1:0] EN_MAX = 2'h3;
  localparam logic signed [7:0] METHOD_RESET = 8'sh00;
  localparam logic signed [7:0] METHOD_MIN = -8'sh02;
  localparam logic signed [7:0] METHOD_MAX = 8'sh23;
  localparam logic signed [7:0] METHOD_STOP_FWD = -8'sh02;
  localparam logic signed [7:0] METHOD_NEG_LIMIT = 8'sh01;
  localparam logic signed [7:0] METHOD_POS_LIMIT = 8'sh02;
  localparam logic signed [7:0] METHOD_HOME_SW = 8'sh03;
  localparam logic [15:0] HIGH_SPEED_RESET = 16'h0064;
  localparam logic [15:0] HIGH_SPEED_MAX = 16'h1F40;
  localparam logic [15:0] LOW_SPEED_RESET = 16'h000A;
  localparam logic [15:0] LOW_SPEED_MAX = 16'h0BB8;
  localparam logic [31:0] RAMP_RESET = 32'h0000_03E8;
  localparam logic [31:0] RAMP_MAX = 32'h0036_EE80;
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_EA60;
  localparam logic OFFMODE_RESET = 1'b0;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;

  // -------------------------------------------------------------------
  // timing: one millisecond tick for the timeout
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic active;
    logic dir_fwd;
    logic [15:0] speed_rpm;
  } motion_cmd_t;

  typedef struct packed {
    logic negative_limit_input;
    logic positive_limit_input;
    logic home_switch_input;
    logic z_index;
    logic end_stop;
  } sensor_in_t;

endpackage

/* homing_axis_model.sv */
// behavioural axis and sensor model that answers the homing sequencer's motion commands
`timescale 1ns/1ps
`default_nettype none
module homing_axis_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the sequencer
  input wire homing_pkg::motion_cmd_t motion_cmd,
  input wire logic goto_zero,
  // sensor and position loop answers
  output homing_pkg::sensor_in_t sensors,
  output logic zero_reached
);
  logic signed [15:0] pos_ff;
  logic [1:0] settle_ff;
  // axis travels one count per cycle while commanded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) pos_ff <= 16'sh0000;
    else if (motion_cmd.active) pos_ff <= motion_cmd.dir_fwd ? pos_ff + 16'sh0001 : pos_ff - 16'sh0001;
  end
  // the offset move takes a few cycles, never an instant answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) settle_ff <= 2'h0;
    else if (!goto_zero) settle_ff <= 2'h0;
    else if (settle_ff != 2'h3) settle_ff <= settle_ff + 2'h1;
  end
  assign zero_reached = (settle_ff == 2'h3);
  // limits twenty counts either side, home switch from 12, end stop from 24, z every eight
  // counts; limits sit close so every pattern ends within a few dozen cycles
  assign sensors = homing_pkg::sensor_in_t'({pos_ff <= -16'sh0014, pos_ff >= 16'sh0014,
                                             pos_ff >= 16'sh000C, pos_ff[2:0] == 3'h0,
                                             pos_ff >= 16'sh0018});
endmodule // homing_axis_model
`default_nettype wire

/* homing_sequencer_tb.sv */
// self-checking testbench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module homing_sequencer_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, homing_request, position_mode;
  logic servo_on, ipos_busy, mpos_busy, goto_zero, pos_ref_accept, done, tmo, zero_reached;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, enc, zero_target, ramp_a, ramp_d, abs_pos;
  homing_pkg::motion_cmd_t motion_cmd;
  homing_pkg::sensor_in_t sensors;
  logic [32:0] exp_q[$];
  int err_count, samples_checked, cycles, seed;
  logic [7:0] ra [0:9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
  logic [32:0] rv [0:9] = '{33'h0, 33'h64, 33'hA, 33'h3E8, 33'h3E8, 33'hEA60, 33'h0, 33'h0,
                            33'h0, 33'h1_0000_0000};
  // short millisecond tick keeps the timeout scenario brief
  homing_sequencer #(.MS_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .homing_request(homing_request),
    .position_mode(position_mode), .servo_on(servo_on), .interrupt_pos_busy(ipos_busy),
    .multipos_busy(mpos_busy), .sensors(sensors), .encoder_position(enc),
    .zero_reached(zero_reached), .motion_cmd(motion_cmd), .ramp_accel_ms(ramp_a),
    .ramp_decel_ms(ramp_d),
    .goto_zero(goto_zero), .zero_target(zero_target), .pos_ref_accept(pos_ref_accept),
    .homing_done_output(done), .homing_timeout_error(tmo), .absolute_position_monitor(abs_pos));
  homing_axis_model i_axis (.pclk(pclk), .presetn(presetn), .motion_cmd(motion_cmd),
    .goto_zero(goto_zero), .sensors(sensors), .zero_reached(zero_reached));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // a clean rising edge on the host trigger
  task req;
    @(posedge pclk) homing_request <= 1'b1;
    repeat (3) @(posedge pclk);
    homing_request <= 1'b0;
    @(negedge pclk);
  endtask
  // one homing run from a control word, waiting for done
  task run(input logic [31:0] ctrl);
    apb(1'b1, 8'h00, ctrl);
    req();
    for (int i = 0; i < 500 && done !== 1'b1; i++) @(negedge pclk);
    check("done", done, 1'b1);
  endtask
  // read data and error flag are compared with the oldest note at the completing edge
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite)
    check("prdata", {pslverr, prdata}, exp_q.pop_front());
  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    seed = 32'h5159;
    enc = $random(seed);
    {presetn, psel, penable, pwrite, homing_request, ipos_busy, mpos_busy} = 7'h0;
    {position_mode, servo_on} = 2'h3;
    paddr = 8'h00; pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    apb(1'b1, 8'h00, 32'h0000_2400);
    apb(1'b1, 8'h04, 32'h0000_1F41);
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h64);
    check("accel", ramp_a, 33'h3E8);
    check("decel", ramp_d, 33'h3E8);
    $display("register test done");
    apb(1'b1, 8'h00, 32'h0000_0201);
    apb(1'b1, 8'h18, 32'h0000_0005);
    ipos_busy <= 1'b1;
    req();
    check("blocked", motion_cmd.active, 1'b0);
    {ipos_busy, mpos_busy} <= 2'h1;
    req();
    check("blocked", motion_cmd.active, 1'b0);
    mpos_busy <= 1'b0;
    req();
    check("motion", motion_cmd, {1'b1, 1'b1, 16'h0064});
    check("accept", pos_ref_accept, 1'b0);
    req();
    for (int i = 0; i < 500 && done !== 1'b1; i++) @(negedge pclk);
    check("done", done, 1'b1);
    check("zero", zero_target, 32'(enc + 32'h5));
    check("accept", pos_ref_accept, 1'b1);
    rd(8'h20, 33'h5);
    rd(8'h1C, 33'h2);
    check("abs", abs_pos, 33'h5);
    position_mode <= 1'b0; servo_on <= 1'b0;
    @(negedge pclk);
    check("done", done, 1'b1);
    position_mode <= 1'b1; servo_on <= 1'b1;
    run(32'h0000_0301);
    apb(1'b1, 8'h18, 32'h0000_0000);
    run(32'h0000_FE01);
    check("zero", zero_target, {1'b0, enc});
    check("abs", abs_pos, 33'h0);
    run(32'h0000_0101);
    $display("homing test done");
    apb(1'b1, 8'h14, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0201);
    req();
    repeat (30) @(negedge pclk);
    check("timeout", {tmo, done, motion_cmd.active}, 3'h4);
    rd(8'h1C, 33'h4);
    apb(1'b1, 8'h00, 32'h0000_0001);
    req();
    rd(8'h1C, 33'hC);
    $display("timeout test done");
    repeat (3) @(posedge pclk);
    end_of_test();
  end
endmodule // homing_sequencer_tb
`default_nettype wire
